// >>> design/instr_bus_pkg.sv
// package: bus message codes, status byte layout and carrier structs for the bus status port
package instr_bus_pkg;
   // multiline interface message codes (ATN true)
   localparam logic [7:0] MSG_GTL = 8'h01;
   localparam logic [7:0] MSG_SDC = 8'h04;
   localparam logic [7:0] MSG_GET = 8'h08;
   localparam logic [7:0] MSG_LLO = 8'h11;
   localparam logic [7:0] MSG_DCL = 8'h14;
   localparam logic [7:0] MSG_SPE = 8'h18;
   localparam logic [7:0] MSG_SPD = 8'h19;
   localparam logic [7:0] MSG_UNL = 8'h3f;
   localparam logic [7:0] MSG_UNT = 8'h5f;
   localparam logic [2:0] GRP_LISTEN = 3'h1;
   localparam logic [2:0] GRP_TALK = 3'h2;
   localparam logic [4:0] ADDR_UNUSED = 5'h1f;
   // status byte bit positions (bit 1 of the manual is index 0)
   localparam int SB_OVR = 0;
   localparam int SB_ZERO = 1;
   localparam int SB_BTN = 2;
   localparam int SB_CAL = 3;
   localparam int SB_DAV = 4;
   localparam int SB_ERR = 5;
   localparam int SB_RQS = 6;
   localparam int SB_EVT_W = 6;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [5:0] MASK_RESET = 6'h00;
   // one trigger character and one clear marker go to the input buffer
   localparam logic [7:0] CHR_TRIGGER = 8'h3f;

   // bus handshake and management lines, already synchronised
   typedef struct packed {
      logic atn;
      logic ifc;
      logic ren;
      logic dav;
      logic [7:0] data;
   } bus_in_s;

   // events reported by the instrument core
   typedef struct packed {
      logic overrange;
      logic srqButton;
      logic calStore;
      logic outLoad;
      logic outRead;
      logic extTrigger;
      logic errorEvent;
   } core_evt_s;

   // requests handed to the instrument core
   typedef struct packed {
      logic queueChar;
      logic [7:0] queueData;
      logic queueClear;
      logic flushInput;
      logic stringEnd;
   } core_req_s;
endpackage

// >>> design/instrument_bus_status_port.sv
// module: bus status byte, service request and interface message decode
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RQ1 - eight-bit status byte readable anytime by poll
// RQ2 - masked bits 1-6 set RQS; RQS drives SRQ
// RQ3 - overrange sets bit 1; bit 2 always zero
// RQ4 - panel request button sets bit 3
// RQ5 - calibration store completion sets bit 4
// RQ6 - every output buffer load sets bit 5
// RQ7 - bus input, read, trigger clear bit 5
// RQ8 - error sets bit 6 with error message
// RQ9 - address messages under ATN act immediately
// RQ10 - universal commands immediate except queued DCL
// RQ11 - ATN true decodes interface, false passes data
// RQ12 - IFC idles only the bus interface
// RQ13 - REN plus listen address gives remote
// RQ14 - DCL queues clear first, flushes input buffer
// RQ15 - LLO disables front-panel local button
// RQ16 - SPE talker sends status byte; SPD cancels
// RQ17 - GET queues one trigger, ends string
// RQ18 - GTL goes local without buffering
// RQ19 - SDC acts as DCL only when listener
// RQ20 - talk-only switch sampled at power-up, IFC
// RQ21 - output data only when addressed talker
// RQ22 - reset clears status byte and SRQ
module instrument_bus_status_port #(
   parameter int ADDR_W = 5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic atnPin,
   input wire logic ifcPin,
   input wire logic renPin,
   input wire logic davPin,
   input wire logic [7:0] dataPin,
   input wire logic [ADDR_W-1:0] busAddress,
   input wire logic talkOnlySwitch,
   input wire logic localButton,
   input wire instr_bus_pkg::core_evt_s coreEvt,
   input wire logic [5:0] requestMask,
   input wire logic [7:0] outBufferData,
   output logic srqOut,
   output logic [7:0] talkData,
   output logic talkValid,
   output logic [7:0] pollStatusByte,
   output logic remoteMode,
   output logic lockoutActive,
   output logic talkOnly,
   output logic listenerActive,
   output logic talkerActive,
   output logic goLocalPulse,
   output instr_bus_pkg::core_req_s coreReq
);
   import instr_bus_pkg::*;

   initial begin
      if (ADDR_W != 5) begin
         $error("bus address must be five bits wide");
      end
   end

   // two-stage synchronisers; stage one is read by stage two only
   logic [11:0] syncA_ff;
   logic [11:0] syncB_ff;
   logic talkSwSyncA_ff;
   logic talkSwSyncB_ff;
   logic davPrev_ff;
   bus_in_s bus;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         syncA_ff <= '0;
         syncB_ff <= '0;
         talkSwSyncA_ff <= 1'b0;
         talkSwSyncB_ff <= 1'b0;
      end else begin
         syncA_ff <= {atnPin, ifcPin, renPin, davPin, dataPin};
         syncB_ff <= syncA_ff;
         talkSwSyncA_ff <= talkOnlySwitch;
         talkSwSyncB_ff <= talkSwSyncA_ff;
      end
   end

   assign bus = bus_in_s'(syncB_ff);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         davPrev_ff <= 1'b0;
      end else begin
         davPrev_ff <= bus.dav;
      end
   end

   // one byte per rising data-valid edge
   logic byteStrobe;
   logic cmdByte;
   logic dataByte;
   assign byteStrobe = bus.dav && !davPrev_ff;
   assign cmdByte = byteStrobe && bus.atn; // see RQ11
   assign dataByte = byteStrobe && !bus.atn; // see RQ11

   logic isListenAddr;
   logic isTalkAddr;
   logic isDcl;
   logic isSdc;
   logic clearReq;
   assign isListenAddr = cmdByte && (bus.data[6:5] == GRP_LISTEN[1:0])
      && (bus.data[4:0] == busAddress) && (busAddress != ADDR_UNUSED);
   assign isTalkAddr = cmdByte && (bus.data[6:5] == GRP_TALK[1:0])
      && (bus.data[4:0] == busAddress) && (busAddress != ADDR_UNUSED);
   assign isDcl = cmdByte && (bus.data[6:0] == MSG_DCL[6:0]);
   assign isSdc = cmdByte && (bus.data[6:0] == MSG_SDC[6:0]) && listenerActive;
   assign clearReq = isDcl || isSdc; // see RQ19

   // addressing state; IFC idles it but leaves measurement setup alone
   logic listen_ff;
   logic talk_ff;
   logic pollMode_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         listen_ff <= 1'b0;
      end else if (bus.ifc) begin
         listen_ff <= 1'b0; // see RQ12
      end else if (isListenAddr) begin
         listen_ff <= 1'b1; // see RQ9
      end else if (cmdByte && bus.data[6:0] == MSG_UNL[6:0]) begin
         listen_ff <= 1'b0; // see RQ9
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         talk_ff <= 1'b0;
      end else if (bus.ifc) begin
         talk_ff <= 1'b0; // see RQ12
      end else if (isTalkAddr) begin
         talk_ff <= 1'b1; // see RQ9
      end else if (cmdByte && (bus.data[6:0] == MSG_UNT[6:0]
            || (bus.data[6:5] == GRP_TALK[1:0] && bus.data[4:0] != busAddress))) begin
         talk_ff <= 1'b0; // see RQ9
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pollMode_ff <= 1'b0;
      end else if (bus.ifc) begin
         pollMode_ff <= 1'b0; // see RQ12
      end else if (cmdByte && bus.data[6:0] == MSG_SPE[6:0]) begin
         pollMode_ff <= 1'b1; // see RQ16
      end else if (cmdByte && bus.data[6:0] == MSG_SPD[6:0]) begin
         pollMode_ff <= 1'b0; // see RQ16
      end
   end

   // talk-only strap: caught once the synchroniser holds real data, and on each IFC
   // capturing earlier would read the reset value of the sync stages, not the switch
   logic [2:0] strapArm_ff;
   logic talkOnly_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         strapArm_ff <= 3'h1;
      end else begin
         strapArm_ff <= {strapArm_ff[1:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         talkOnly_ff <= 1'b0;
      end else if (strapArm_ff[2] || bus.ifc) begin
         talkOnly_ff <= talkSwSyncB_ff; // see RQ20
      end
   end

   // remote and lockout; IFC does not touch these
   logic remote_ff;
   logic lockout_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         remote_ff <= 1'b0;
      end else if (!bus.ren) begin
         remote_ff <= 1'b0; // see RQ13
      end else if (isListenAddr) begin
         remote_ff <= 1'b1; // see RQ13
      end else if (cmdByte && bus.data[6:0] == MSG_GTL[6:0] && listenerActive) begin
         remote_ff <= 1'b0; // see RQ18
      end else if (localButton && !lockout_ff) begin
         remote_ff <= 1'b0; // see RQ15
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lockout_ff <= 1'b0;
      end else if (!bus.ren) begin
         lockout_ff <= 1'b0; // see RQ13
      end else if (cmdByte && bus.data[6:0] == MSG_LLO[6:0]) begin
         lockout_ff <= 1'b1; // see RQ15
      end
   end

   // input buffer requests: only DCL/SDC, GET and data characters are queued
   core_req_s req_ff;
   logic goLocal_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_ff <= '0;
      end else begin
         req_ff.queueClear <= clearReq; // see RQ10, RQ14
         req_ff.flushInput <= clearReq; // see RQ14
         if (cmdByte && bus.data[6:0] == MSG_GET[6:0] && listenerActive) begin
            req_ff.queueChar <= 1'b1; // see RQ17
            req_ff.queueData <= CHR_TRIGGER;
            req_ff.stringEnd <= 1'b1; // see RQ17
         end else if (dataByte && listenerActive) begin
            req_ff.queueChar <= 1'b1; // see RQ11
            req_ff.queueData <= bus.data;
            req_ff.stringEnd <= 1'b0;
         end else begin
            req_ff.queueChar <= 1'b0;
            req_ff.stringEnd <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         goLocal_ff <= 1'b0;
      end else begin
         goLocal_ff <= cmdByte && bus.data[6:0] == MSG_GTL[6:0] && listenerActive; // see RQ18
      end
   end

   // status byte; set wins over clear
   logic [SB_EVT_W-1:0] status_ff;
   logic [SB_EVT_W-1:0] evtSet;
   logic davClear;
   assign evtSet[SB_OVR] = coreEvt.overrange; // see RQ3
   assign evtSet[SB_ZERO] = 1'b0; // see RQ3
   assign evtSet[SB_BTN] = coreEvt.srqButton; // see RQ4
   assign evtSet[SB_CAL] = coreEvt.calStore; // see RQ5
   assign evtSet[SB_DAV] = coreEvt.outLoad || coreEvt.errorEvent; // see RQ6, RQ8
   assign evtSet[SB_ERR] = coreEvt.errorEvent; // see RQ8
   assign davClear = byteStrobe || coreEvt.outRead || coreEvt.extTrigger; // see RQ7

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_ff <= STATUS_RESET[SB_EVT_W-1:0]; // see RQ22
      end else begin
         status_ff <= status_ff | evtSet;
         if (davClear && !evtSet[SB_DAV]) begin
            status_ff[SB_DAV] <= 1'b0; // see RQ7
         end
         status_ff[SB_ZERO] <= 1'b0; // see RQ3
      end
   end

   logic rqs;
   assign rqs = |(status_ff & requestMask); // see RQ2

   logic [7:0] pollByte;
   assign pollByte = {1'b0, rqs, status_ff};

   // talker output: status byte during poll, else output buffer data
   logic [7:0] talkData_ff;
   logic talkValid_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         talkData_ff <= 8'h00;
         talkValid_ff <= 1'b0;
      end else begin
         // ifc drops the talker in this same edge, so it must gate the output too
         talkValid_ff <= (talk_ff || talkOnly_ff) && !bus.atn && !bus.ifc; // see RQ21
         if (pollMode_ff) begin
            talkData_ff <= pollByte; // see RQ1, RQ16
         end else begin
            talkData_ff <= outBufferData; // see RQ21
         end
      end
   end

   logic srq_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         srq_ff <= 1'b0; // see RQ22
      end else begin
         srq_ff <= rqs; // see RQ2
      end
   end

   assign srqOut = srq_ff;
   assign pollStatusByte = pollByte; // see RQ1
   assign talkData = talkData_ff;
   assign talkValid = talkValid_ff;
   assign remoteMode = remote_ff;
   assign lockoutActive = lockout_ff;
   assign talkOnly = talkOnly_ff;
   assign listenerActive = listen_ff;
   assign talkerActive = talk_ff || talkOnly_ff;
   assign goLocalPulse = goLocal_ff;
   assign coreReq = req_ff;
endmodule

`default_nettype wire

// >>> testbench/instr_port_chk_asserts.sv
// checker: status byte, service request and message decode relations
`timescale 1ns/1ps
`default_nettype none
module instr_port_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic atnPin,
   input wire logic davPin,
   input wire logic [7:0] dataPin,
   input wire instr_bus_pkg::core_evt_s coreEvt,
   input wire logic [5:0] requestMask,
   input wire logic srqOut,
   input wire logic [7:0] pollStatusByte,
   input wire logic talkValid,
   input wire logic talkerActive,
   input wire logic talkOnly,
   input wire instr_bus_pkg::core_req_s coreReq
);
   import instr_bus_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // pin edge, two sync stages, then the registered request
   sequence dclTaken;
      $rose(davPin) && atnPin && dataPin == MSG_DCL;
   endsequence
   sequence clearIssued;
      coreReq.queueClear && coreReq.flushInput;
   endsequence
   chk_unused_zero: assert property (!pollStatusByte[SB_ZERO] && !pollStatusByte[7])
      else $error("unused status bit set");
   chk_rqs_mask: assert property (pollStatusByte[SB_RQS] == |(pollStatusByte[5:0] & requestMask))
      else $error("request bit wrong");
   chk_srq_follow: assert property (srqOut == $past(pollStatusByte[SB_RQS]))
      else $error("service request wrong");
   chk_ovr_set: assert property (coreEvt.overrange |=> pollStatusByte[SB_OVR])
      else $error("overrange bit not set");
   chk_btn_set: assert property (coreEvt.srqButton |=> pollStatusByte[SB_BTN])
      else $error("button bit not set");
   chk_dav_set: assert property ((coreEvt.outLoad || coreEvt.errorEvent) |=> pollStatusByte[SB_DAV])
      else $error("data bit not set");
   chk_err_set: assert property (coreEvt.errorEvent |=> pollStatusByte[SB_ERR])
      else $error("error bit not set");
   chk_dav_clear: assert property ((coreEvt.outRead || coreEvt.extTrigger) && !coreEvt.outLoad
      && !coreEvt.errorEvent |=> !pollStatusByte[SB_DAV])
      else $error("data bit not cleared");
   chk_dcl_queue: assert property (dclTaken |-> ##[2:4] clearIssued)
      else $error("device clear not queued");
   chk_talk_gate: assert property (talkValid |-> talkerActive || talkOnly)
      else $error("talking while not talker");
endmodule
bind instrument_bus_status_port instr_port_chk i_instr_port_chk (.*);
`default_nettype wire

// >>> testbench/ctrl_model.sv
// partner model: system controller driving the management and data lines
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
   input wire logic clk,
   output logic atnPin,
   output logic ifcPin,
   output logic renPin,
   output logic davPin,
   output logic [7:0] dataPin
);
   initial {atnPin, ifcPin, renPin, davPin, dataPin} = 12'h000;
   // atn and the byte stand through the whole handshake
   task automatic send(input logic a, input logic [7:0] b);
      @(posedge clk);
      atnPin <= a;
      dataPin <= b;
      davPin <= 1'b1;
      repeat (4) @(posedge clk);
      davPin <= 1'b0;
      atnPin <= 1'b0;
      dataPin <= ~b; // released lines must not keep showing the byte
      repeat (4) @(posedge clk);
   endtask
   task automatic setRen(input logic v);
      @(posedge clk);
      renPin <= v;
   endtask
   task automatic pulseIfc();
      @(posedge clk);
      ifcPin <= 1'b1;
      repeat (4) @(posedge clk);
      ifcPin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> testbench/instrument_bus_status_port_tb.sv
// testbench: controller traffic, core events and expected port values
`timescale 1ns/1ps
`default_nettype none
module instrument_bus_status_port_tb;
   import instr_bus_pkg::*;
   localparam logic [4:0] ADR = 5'h04;
   logic clk, resetn, atnPin, ifcPin, renPin, davPin, talkOnlySwitch, localButton;
   logic [7:0] dataPin, talkData, pollStatusByte, lastChar;
   logic [4:0] busAddress = ADR;
   logic [7:0] outBufferData = 8'ha5;
   logic [5:0] requestMask;
   core_evt_s coreEvt;
   core_req_s coreReq;
   logic srqOut, talkValid, remoteMode, lockoutActive, talkOnly, listenerActive;
   logic talkerActive, goLocalPulse;
   logic [3:0] nChar = 0, nClr = 0, nEnd = 0, nGo = 0;
   int errCount = 0, samplesChecked = 0;
   logic [7:0] expTab [8] = '{8'h01, 8'h05, 8'h0d, 8'h1d, 8'h0d, 8'h1d, 8'h0d, 8'h3d};
   int evTab [8] = '{6, 5, 4, 3, 2, 3, 1, 0};
   wire logic [7:0] flags = {2'h0, talkOnly, talkerActive, listenerActive, remoteMode,
      lockoutActive, talkValid};
   instrument_bus_status_port i_instrument_bus_status_port (.*);
   ctrl_model i_ctrl_model (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pulses are counted so that one-cycle requests are not missed between checks
   always @(posedge clk) begin
      if (coreReq.queueChar === 1'b1) begin
         nChar <= nChar + 4'h1;
         lastChar <= coreReq.queueData;
      end
      nClr <= nClr + {3'h0, coreReq.queueClear};
      nEnd <= nEnd + {3'h0, coreReq.stringEnd};
      nGo <= nGo + {3'h0, goLocalPulse};
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         errCount++;
      end
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      coreEvt <= core_evt_s'(7'h01 << k);
      @(posedge clk);
      coreEvt <= '0;
      repeat (3) @(posedge clk);
   endtask
   task results;
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {resetn, talkOnlySwitch, localButton} = 3'b000;
      coreEvt = '0;
      requestMask = 6'h00;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk({srqOut, pollStatusByte[6:0]}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         pulse(evTab[i]);
         chk(pollStatusByte, expTab[i]);
      end
      requestMask <= 6'h02;
      repeat (3) @(posedge clk);
      chk({srqOut, pollStatusByte[6:0]}, 8'h3d);
      requestMask <= 6'h20;
      repeat (3) @(posedge clk);
      chk({srqOut, pollStatusByte[6:0]}, 8'hfd);
      i_ctrl_model.setRen(1'b1);
      i_ctrl_model.send(1'b1, {3'h1, ADR});
      chk(flags, 8'h0c);
      chk(pollStatusByte, 8'h6d);
      i_ctrl_model.send(1'b0, 8'h44);
      i_ctrl_model.send(1'b0, 8'h30); // unblank the display before going local
      chk({nChar, nClr}, 8'h20);
      chk(lastChar, 8'h30);
      i_ctrl_model.send(1'b1, MSG_GET);
      chk(lastChar, CHR_TRIGGER);
      i_ctrl_model.send(1'b1, MSG_DCL);
      chk({nChar, nClr}, 8'h31);
      chk({nEnd, nGo}, 8'h10);
      i_ctrl_model.send(1'b1, MSG_LLO);
      localButton <= 1'b1;
      repeat (4) @(posedge clk);
      chk(flags, 8'h0e);
      localButton <= 1'b0;
      i_ctrl_model.send(1'b1, MSG_GTL);
      chk({nEnd, nGo}, 8'h11);
      chk(flags, 8'h0a);
      i_ctrl_model.setRen(1'b0);
      repeat (4) @(posedge clk);
      chk(flags, 8'h08);
      i_ctrl_model.send(1'b1, MSG_UNL);
      i_ctrl_model.send(1'b1, MSG_SDC);
      i_ctrl_model.send(1'b1, MSG_GET);
      chk({nEnd, nClr}, 8'h11);
      chk(flags, 8'h00);
      i_ctrl_model.send(1'b1, {3'h2, ADR});
      chk(flags, 8'h11);
      chk(talkData, 8'ha5);
      i_ctrl_model.send(1'b1, MSG_SPE);
      chk(talkData, 8'h6d);
      i_ctrl_model.send(1'b1, MSG_SPD);
      chk(talkData, 8'ha5);
      i_ctrl_model.send(1'b1, {3'h1, ADR});
      talkOnlySwitch <= 1'b1;
      i_ctrl_model.pulseIfc();
      chk({talkOnly, listenerActive, pollStatusByte[5:0]}, 8'had);
      results();
   end
   // the sequence needs about two hundred cycles; twenty times that means a hang
   initial begin
      repeat (4000) @(posedge clk);
      errCount++;
      results();
   end
endmodule
`default_nettype wire
